// [verilog/tcp_params.svh]
// Constants for the timer, capture and pulse output control block.
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define TCP_ADDR_W 8
`define TCP_OFF_CTRL 8'h17
`define TCP_OFF_CAP_A_LO 8'h18
`define TCP_OFF_CAP_A_HI 8'h19
`define TCP_OFF_CAP_B_LO 8'h1a
`define TCP_OFF_CAP_B_HI 8'h1b
`define TCP_OFF_IRQ_STAT 8'h1c
`define TCP_OFF_IRQ_EN 8'h1d
`define TCP_OFF_IRQ_CLR 8'h1e

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define TCP_BIT_CAP_B_OVF 7
`define TCP_BIT_CAP_A_OVF 6
`define TCP_BIT_PULSE_B_EN 5
`define TCP_BIT_PULSE_A_EN 4
`define TCP_BIT_CAP_OR_PERIOD 3
`define TCP_BIT_TIMER_C_RUN 2
`define TCP_BIT_TIMER_B_RUN 1
`define TCP_BIT_TIMER_A_RUN 0
`define TCP_CTRL_RW_RESET 6'h00
`define TCP_CTRL_RW_MASK 8'h3f

// ---------------------------------------------------------------------------
// Port B pins shared with the pulse outputs
// ---------------------------------------------------------------------------
`define TCP_PORTB_BIT_PULSE_A 2
`define TCP_PORTB_BIT_PULSE_B 3

// ---------------------------------------------------------------------------
// Interrupt status bits
// ---------------------------------------------------------------------------
`define TCP_IRQ_CAP_A 0
`define TCP_IRQ_CAP_B 1
`define TCP_IRQ_OVF_A 2
`define TCP_IRQ_OVF_B 3
`define TCP_IRQ_W 4
`define TCP_IRQ_RESET 4'h0

`endif

// [verilog/tcp_pkg.sv]
// Types for the timer, capture and pulse output control block.
package tcp_pkg;

    typedef struct packed {
        logic [15:0] value;
        logic full;
        logic lo_seen;
        logic hi_seen;
        logic overrun;
        logic cap_evt;
        logic ovf_evt;
    } tcp_cap_state_t;

    typedef struct packed {
        logic [5:0] ctrl_rw;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [7:0] rdata;
        logic irq;
        logic a_en;
        logic b_en;
        logic c_en;
        logic joined;
        logic c_limit;
        logic cap_a_sel;
        logic oe_a;
        logic oe_b;
        logic pin_a;
        logic pin_b;
    } tcp_state_t;

endpackage

// [verilog/tcp_capture.sv]
// One capture channel: holds the oldest unread timer value and flags overruns.
`timescale 1ns/1ps
`default_nettype none

module tcp_capture (
    input wire logic clk_sys_in,          // System clock.
    input wire logic rstn_in,             // Asynchronous reset, active low.
    input wire logic enable_in,           // Channel may capture.
    input wire logic event_in,            // Capture event, one cycle.
    input wire logic [15:0] value_in,     // Timer value to capture.
    input wire logic rd_lo_in,            // Low byte read this cycle.
    input wire logic rd_hi_in,            // High byte read this cycle.
    output logic [15:0] value_out,        // Held capture value.
    output logic full_out,                // Value held and not yet read.
    output logic overrun_out,             // Overrun flag.
    output logic cap_evt_out,             // Pulse: value was loaded.
    output logic ovf_evt_out              // Pulse: overrun occurred.
);

    tcp_pkg::tcp_cap_state_t s_reg;
    tcp_pkg::tcp_cap_state_t s_next;
    logic done;

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------
    // The pair counts as read once both bytes were read in any order.
    always_comb begin
        done = s_reg.full & (s_reg.lo_seen | rd_lo_in) & (s_reg.hi_seen | rd_hi_in);
        s_next = s_reg;
        s_next.cap_evt = 1'b0;
        s_next.ovf_evt = 1'b0;
        if (s_reg.full) begin
            s_next.lo_seen = s_reg.lo_seen | rd_lo_in;
            s_next.hi_seen = s_reg.hi_seen | rd_hi_in;
        end
        if (done) begin
            s_next.full = 1'b0;
            s_next.lo_seen = 1'b0;
            s_next.hi_seen = 1'b0;
            s_next.overrun = 1'b0;
        end
        if (enable_in && event_in) begin
            if (!s_reg.full || done) begin  // [RQ2] [RQ3]
                // A pair freed in this very cycle takes the new value at once.
                s_next.value = value_in;
                s_next.full = 1'b1;
                s_next.cap_evt = 1'b1;
            end else begin
                s_next.overrun = 1'b1;   // [RQ1] [RQ3]
                s_next.ovf_evt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign value_out = s_reg.value;
    assign full_out = s_reg.full;
    assign overrun_out = s_reg.overrun;
    assign cap_evt_out = s_reg.cap_evt;
    assign ovf_evt_out = s_reg.ovf_evt;

endmodule

`default_nettype wire

// [verilog/tcp_ctrl.sv]
// Control and status register for the timer, capture and pulse output group.
//
// Overview of operation
// [RQ1] Capture B overrun flag set on unread capture
// [RQ2] Capture B keeps oldest value until read
// [RQ3] Capture A overrun flag, holds oldest value
// [RQ4] Pulse B enable forces pin B output
// [RQ5] Pulse A enable forces pin A output
// [RQ6] Select bit: capture A or timer C period
// [RQ7] Timer C counts only while run set
// [RQ8] Timer B counts only while run set
// [RQ9] Timer A run starts joined or single counter
// [RQ10] Joining bit merges timers A and B
// [RQ11] Overrun flags read-only; reset clears everything
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"

module tcp_ctrl (
    input wire logic clk_sys_in,               // System clock, 200 MHz.
    input wire logic rstn_in,                  // Asynchronous reset, active low.
    input wire logic [7:0] addr_in,            // Register address.
    input wire logic [7:0] wdata_in,           // Write data.
    input wire logic wr_in,                    // Write strobe.
    input wire logic rd_in,                    // Read strobe.
    output logic [7:0] rdata_out,              // Read data, cycle after strobe.
    input wire logic joined_counter_mode_in,   // Joining bit from timer config.
    input wire logic [15:0] timer_c_value_in,  // Timer C count to capture.
    input wire logic cap_a_event_in,           // Capture A event pulse.
    input wire logic cap_b_event_in,           // Capture B event pulse.
    input wire logic [7:0] port_b_direction_in, // Port B direction, 1 drives.
    input wire logic [7:0] port_b_data_in,     // Port B output latch.
    input wire logic pulse_a_wave_in,          // Pulse A waveform.
    input wire logic pulse_b_wave_in,          // Pulse B waveform.
    output logic pulse_a_pin_out,              // Pin A output value.
    output logic pulse_a_pin_oe_out,           // Pin A output enable.
    output logic pulse_b_pin_out,              // Pin B output value.
    output logic pulse_b_pin_oe_out,           // Pin B output enable.
    output logic timer_a_count_en_out,         // Timer A may count.
    output logic timer_b_count_en_out,         // Timer B may count.
    output logic timer_c_count_en_out,         // Timer C may count.
    output logic joined_counter_mode_out,      // Timers A and B joined.
    output logic timer_c_period_en_out,        // Timer C wraps at period.
    output logic capture_a_en_out,             // Capture A active.
    output logic [15:0] capture_a_value_out,   // Capture A held value.
    output logic [15:0] capture_b_value_out,   // Capture B held value.
    output logic irq_out                       // Level interrupt.
);

    tcp_pkg::tcp_state_t s_reg;
    tcp_pkg::tcp_state_t s_next;

    logic [15:0] cap_a_val;
    logic [15:0] cap_b_val;
    logic [1:0][15:0] cap_val;
    logic [1:0] cap_en;
    logic [1:0] cap_ev;
    logic [1:0][7:0] cap_lo_addr;
    logic [1:0][7:0] cap_hi_addr;
    logic [1:0] cap_full;
    logic [1:0] cap_ovf;
    logic [1:0] cap_evt;
    logic [1:0] ovf_evt;
    logic [1:0] rd_lo;
    logic [1:0] rd_hi;
    logic [7:0] ctrl_view;
    logic [3:0] evts;

    // -----------------------------------------------------------------------
    // Capture channels
    // -----------------------------------------------------------------------
    // Capture A only runs while the shared pair is not the period register.
    assign cap_en = {1'b1, s_reg.ctrl_rw[`TCP_BIT_CAP_OR_PERIOD]};  // [RQ6]
    assign cap_ev = {cap_b_event_in, cap_a_event_in};
    assign cap_lo_addr = {`TCP_OFF_CAP_B_LO, `TCP_OFF_CAP_A_LO};
    assign cap_hi_addr = {`TCP_OFF_CAP_B_HI, `TCP_OFF_CAP_A_HI};

    // Both channels latch the same timer C count; only their events, enables and read addresses differ.
    for (genvar ch = 0; ch < 2; ch++) begin : g_cap
        assign rd_lo[ch] = rd_in && addr_in == cap_lo_addr[ch];
        assign rd_hi[ch] = rd_in && addr_in == cap_hi_addr[ch];
        tcp_capture u_cap (
            .clk_sys_in(clk_sys_in),
            .rstn_in(rstn_in),
            .enable_in(cap_en[ch]),
            .event_in(cap_ev[ch]),
            .value_in(timer_c_value_in),
            .rd_lo_in(rd_lo[ch]),
            .rd_hi_in(rd_hi[ch]),
            .value_out(cap_val[ch]),
            .full_out(cap_full[ch]),
            .overrun_out(cap_ovf[ch]),
            .cap_evt_out(cap_evt[ch]),
            .ovf_evt_out(ovf_evt[ch])
        );
    end

    assign cap_a_val = cap_val[0];
    assign cap_b_val = cap_val[1];

    assign capture_a_value_out = cap_a_val;
    assign capture_b_value_out = cap_b_val;

    // -----------------------------------------------------------------------
    // Register file and derived controls
    // -----------------------------------------------------------------------
    // Overrun flags are taken live from the channels, so writes cannot reach them.
    assign ctrl_view = {cap_ovf[1], cap_ovf[0], s_reg.ctrl_rw};  // [RQ11]
    assign evts = {ovf_evt[1], ovf_evt[0], cap_evt[1], cap_evt[0]};

    always_comb begin
        s_next = s_reg;
        if (wr_in && addr_in == `TCP_OFF_CTRL) begin
            s_next.ctrl_rw = wdata_in[5:0];  // [RQ11]
        end
        if (wr_in && addr_in == `TCP_OFF_IRQ_EN) begin
            s_next.irq_en = wdata_in[3:0];
        end
        // A new event wins over a clear written in the same cycle.
        if (wr_in && addr_in == `TCP_OFF_IRQ_CLR) begin
            s_next.irq_stat = (s_reg.irq_stat & ~wdata_in[3:0]) | evts;
        end else begin
            s_next.irq_stat = s_reg.irq_stat | evts;
        end
        s_next.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                `TCP_OFF_CTRL: s_next.rdata = ctrl_view;
                `TCP_OFF_CAP_A_LO: s_next.rdata = cap_a_val[7:0];
                `TCP_OFF_CAP_A_HI: s_next.rdata = cap_a_val[15:8];
                `TCP_OFF_CAP_B_LO: s_next.rdata = cap_b_val[7:0];
                `TCP_OFF_CAP_B_HI: s_next.rdata = cap_b_val[15:8];
                `TCP_OFF_IRQ_STAT: s_next.rdata = {4'h0, s_reg.irq_stat};
                `TCP_OFF_IRQ_EN: s_next.rdata = {4'h0, s_reg.irq_en};
                default: s_next.rdata = 8'h00;
            endcase
        end
        s_next.irq = |(s_reg.irq_stat & s_reg.irq_en);
        s_next.joined = joined_counter_mode_in;  // [RQ10]
        s_next.a_en = s_reg.ctrl_rw[`TCP_BIT_TIMER_A_RUN];  // [RQ9]
        // Joined, the upper byte needs both run bits to carry in.
        s_next.b_en = s_reg.ctrl_rw[`TCP_BIT_TIMER_B_RUN]
            & (~joined_counter_mode_in | s_reg.ctrl_rw[`TCP_BIT_TIMER_A_RUN]);  // [RQ8] [RQ9]
        s_next.c_en = s_reg.ctrl_rw[`TCP_BIT_TIMER_C_RUN];  // [RQ7]
        s_next.cap_a_sel = s_reg.ctrl_rw[`TCP_BIT_CAP_OR_PERIOD];  // [RQ6]
        s_next.c_limit = ~s_reg.ctrl_rw[`TCP_BIT_CAP_OR_PERIOD];  // [RQ6]
        s_next.oe_a = s_reg.ctrl_rw[`TCP_BIT_PULSE_A_EN]
            | port_b_direction_in[`TCP_PORTB_BIT_PULSE_A];  // [RQ5]
        s_next.oe_b = s_reg.ctrl_rw[`TCP_BIT_PULSE_B_EN]
            | port_b_direction_in[`TCP_PORTB_BIT_PULSE_B];  // [RQ4]
        s_next.pin_a = s_reg.ctrl_rw[`TCP_BIT_PULSE_A_EN] ? pulse_a_wave_in
            : port_b_data_in[`TCP_PORTB_BIT_PULSE_A];  // [RQ5]
        s_next.pin_b = s_reg.ctrl_rw[`TCP_BIT_PULSE_B_EN] ? pulse_b_wave_in
            : port_b_data_in[`TCP_PORTB_BIT_PULSE_B];  // [RQ4]
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_reg <= '0;  // [RQ11]
        end else begin
            s_reg <= s_next;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    assign rdata_out = s_reg.rdata;
    assign irq_out = s_reg.irq;
    assign timer_a_count_en_out = s_reg.a_en;
    assign timer_b_count_en_out = s_reg.b_en;
    assign timer_c_count_en_out = s_reg.c_en;
    assign joined_counter_mode_out = s_reg.joined;
    assign timer_c_period_en_out = s_reg.c_limit;
    assign capture_a_en_out = s_reg.cap_a_sel;
    assign pulse_a_pin_out = s_reg.pin_a;
    assign pulse_a_pin_oe_out = s_reg.oe_a;
    assign pulse_b_pin_out = s_reg.pin_b;
    assign pulse_b_pin_oe_out = s_reg.oe_b;

    // -----------------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------------
    AST_B_OVF_SET: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ1]
        cap_b_event_in && cap_full[1] && !rd_lo[1] && !rd_hi[1] |=> cap_ovf[1] && ovf_evt[1])
        else $error("Capture B overrun not flagged");

    AST_B_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ2]
        cap_full[1] && !rd_lo[1] && !rd_hi[1] |=> $stable(cap_b_val) && cap_full[1])
        else $error("Capture B value changed while unread");

    AST_A_OVF_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ3]
        cap_a_event_in && cap_full[0] && !rd_lo[0] && !rd_hi[0]
        && s_reg.ctrl_rw[`TCP_BIT_CAP_OR_PERIOD] |=> cap_ovf[0] && $stable(cap_a_val))
        else $error("Capture A overrun not handled");

    AST_PIN_B: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ4]
        rstn_in |=> pulse_b_pin_oe_out == ($past(s_reg.ctrl_rw[`TCP_BIT_PULSE_B_EN])
        | $past(port_b_direction_in[`TCP_PORTB_BIT_PULSE_B])))
        else $error("Pin B direction wrong");

    AST_PIN_A: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ5]
        s_reg.ctrl_rw[`TCP_BIT_PULSE_A_EN] |=> pulse_a_pin_oe_out)
        else $error("Pin A not driven while pulse A enabled");

    AST_SELECT: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ6]
        !s_reg.ctrl_rw[`TCP_BIT_CAP_OR_PERIOD] && cap_a_event_in && !cap_full[0]
        |=> !cap_full[0] && !capture_a_en_out && timer_c_period_en_out)
        else $error("Capture A acted while pair is the period register");

    AST_C_RUN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ7]
        wr_in && addr_in == `TCP_OFF_CTRL |=> ##1
        timer_c_count_en_out == $past(wdata_in[`TCP_BIT_TIMER_C_RUN], 2))
        else $error("Timer C run not applied two cycles after write");

    AST_B_RUN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ8]
        !s_reg.ctrl_rw[`TCP_BIT_TIMER_B_RUN] |=> !timer_b_count_en_out)
        else $error("Timer B counts while stopped");

    AST_JOIN_RUN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ9]
        joined_counter_mode_in && !s_reg.ctrl_rw[`TCP_BIT_TIMER_A_RUN]
        |=> !timer_a_count_en_out && !timer_b_count_en_out)
        else $error("Joined counter runs with timer A run clear");

    AST_JOIN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ10]
        !joined_counter_mode_in && s_reg.ctrl_rw[`TCP_BIT_TIMER_B_RUN]
        |=> joined_counter_mode_out == 1'b0 && timer_b_count_en_out)
        else $error("Independent timer B not running");

    AST_RO_FLAGS: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ11]
        wr_in && addr_in == `TCP_OFF_CTRL && !cap_b_event_in && !rd_lo[1] && !rd_hi[1]
        |=> $stable(cap_ovf[1]))
        else $error("Control write changed an overrun flag");

    AST_RO_FLAGS_A: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ11]
        wr_in && addr_in == `TCP_OFF_CTRL && !cap_a_event_in && !rd_lo[0] && !rd_hi[0]
        |=> $stable(cap_ovf[0]))
        else $error("Control write changed capture A overrun flag");

    AST_CAP_LOAD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ2]
        cap_b_event_in && !cap_full[1]
        |=> cap_full[1] && cap_b_val == $past(timer_c_value_in))
        else $error("Capture B did not load an empty pair");

    AST_B_OVF_STICK: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ2]
        cap_ovf[1] && !rd_lo[1] && !rd_hi[1] |=> cap_ovf[1])
        else $error("Capture B overrun cleared without a read");

    AST_A_OVF_STICK: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ3]
        cap_ovf[0] && !rd_lo[0] && !rd_hi[0] |=> cap_ovf[0])
        else $error("Capture A overrun cleared without a read");

    AST_A_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ3]
        cap_full[0] && !rd_lo[0] && !rd_hi[0] |=> $stable(cap_a_val) && cap_full[0])
        else $error("Capture A value changed while unread");

    AST_PIN_A_DIR: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ5]
        rstn_in |=> pulse_a_pin_oe_out == ($past(s_reg.ctrl_rw[`TCP_BIT_PULSE_A_EN])
        | $past(port_b_direction_in[`TCP_PORTB_BIT_PULSE_A])))
        else $error("Pin A direction wrong");

    // The shared pair is never period and capture register at once.
    AST_PERIOD_XOR: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ6]
        rstn_in |=> timer_c_period_en_out != capture_a_en_out)
        else $error("Period limit and capture A both on or both off");

    AST_C_STOP: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ7]
        !s_reg.ctrl_rw[`TCP_BIT_TIMER_C_RUN] |=> !timer_c_count_en_out)
        else $error("Timer C counts while stopped");

    AST_JOIN_BOTH: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ8]
        joined_counter_mode_in && s_reg.ctrl_rw[`TCP_BIT_TIMER_A_RUN]
        && s_reg.ctrl_rw[`TCP_BIT_TIMER_B_RUN]
        |=> timer_a_count_en_out && timer_b_count_en_out)
        else $error("Joined counter halted with both run bits set");

    AST_A_STOP: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)  // [RQ9]
        !s_reg.ctrl_rw[`TCP_BIT_TIMER_A_RUN] |=> !timer_a_count_en_out)
        else $error("Timer A counts while stopped");

    // Looked at one edge after reset is seen low; the flops clear asynchronously as soon as reset falls.
    AST_RESET_CLEAR: assert property (@(posedge clk_sys_in)  // [RQ11]
        !rstn_in |=> ctrl_view == 8'h00 && !irq_out && rdata_out == 8'h00)
        else $error("Register not cleared by reset");

    AST_RDATA_IDLE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        !rd_in |=> rdata_out == 8'h00)
        else $error("Read data present without a read strobe");

    // A status event must survive a clear written in the same cycle.
    AST_IRQ_SET_WINS: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        |evts |=> (s_reg.irq_stat & $past(evts)) == $past(evts))
        else $error("Status event lost");

endmodule

`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the timer, capture and pulse output control register.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"

module testbench;
    // ------------------------------------------------------------------------
    // Stimulus and design
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] w;
        logic j;
        logic [7:0] dir;
        logic [7:0] e;
    } tcp_row_t;

    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic joined_in = 1'b0;
    logic [15:0] tval = 16'h0000;
    logic cap_a_ev = 1'b0;
    logic cap_b_ev = 1'b0;
    logic [7:0] dir_in = 8'h00;
    logic [7:0] rdata_out;
    logic pin_a, oe_a, pin_b, oe_b, en_a, en_b, en_c, joined_out, period_en, cap_a_en, irq_out;
    logic [15:0] cap_a_val, cap_b_val;
    logic [7:0] ctl_outs;
    int n_errors = 0;
    int checks_done = 0;
    tcp_row_t rows [11];

    always #2.5 clk_sys_in = ~clk_sys_in;

    assign ctl_outs = {en_a, en_b, en_c, joined_out, period_en, cap_a_en, oe_a, oe_b};

    tcp_ctrl tcp_ctrl_i (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .joined_counter_mode_in(joined_in), .timer_c_value_in(tval),
        .cap_a_event_in(cap_a_ev), .cap_b_event_in(cap_b_ev),
        .port_b_direction_in(dir_in), .port_b_data_in(8'h08),
        .pulse_a_wave_in(1'b1), .pulse_b_wave_in(1'b0),
        .pulse_a_pin_out(pin_a), .pulse_a_pin_oe_out(oe_a),
        .pulse_b_pin_out(pin_b), .pulse_b_pin_oe_out(oe_b),
        .timer_a_count_en_out(en_a), .timer_b_count_en_out(en_b),
        .timer_c_count_en_out(en_c), .joined_counter_mode_out(joined_out),
        .timer_c_period_en_out(period_en), .capture_a_en_out(cap_a_en),
        .capture_a_value_out(cap_a_val), .capture_b_value_out(cap_b_val),
        .irq_out(irq_out)
    );

    // ------------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask

    // The read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        chk(16'(rdata_out), 16'(exp));
    endtask

    task automatic ev(input bit ch, input logic [15:0] v);
        @(posedge clk_sys_in);
        tval <= v;
        if (ch) cap_b_ev <= 1'b1;
        else cap_a_ev <= 1'b1;
        @(posedge clk_sys_in);
        cap_a_ev <= 1'b0;
        cap_b_ev <= 1'b0;
        #1;
    endtask

    task automatic tally_and_finish;
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        #100000;
        n_errors++;
        tally_and_finish;
    end

    initial begin
        logic [7:0] flag, lo;
        // Expected column: a, b, c run, joined, period in use, capture A, oe A, oe B.
        rows = '{'{8'h01, 1'b0, 8'h00, 8'h88}, '{8'h02, 1'b0, 8'h00, 8'h48},
                 '{8'h02, 1'b1, 8'h00, 8'h18}, '{8'h03, 1'b1, 8'h00, 8'hd8},
                 '{8'h04, 1'b0, 8'h00, 8'h28}, '{8'h08, 1'b0, 8'h00, 8'h04},
                 '{8'h10, 1'b0, 8'h00, 8'h0a}, '{8'h20, 1'b0, 8'h00, 8'h09},
                 '{8'h00, 1'b0, 8'h0c, 8'h0b}, '{8'h00, 1'b0, 8'h00, 8'h08},
                 '{8'hff, 1'b1, 8'h00, 8'hf7}};
        repeat (10) @(posedge clk_sys_in);
        chk(16'(ctl_outs), 16'h0000);
        rstn_in <= 1'b1;
        rdchk(`TCP_OFF_CTRL, 8'h00);
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_sys_in);
            joined_in <= rows[i].j;
            dir_in <= rows[i].dir;
            wr(`TCP_OFF_CTRL, rows[i].w);
            tick(1);
            chk(16'(ctl_outs), 16'(rows[i].e));
            chk(16'({pin_a, pin_b}), 16'({rows[i].w[4], ~rows[i].w[5]}));
            rdchk(`TCP_OFF_CTRL, rows[i].w & 8'h3f);
        end
        // Overrun on each channel: the oldest value stays until both bytes are read.
        wr(`TCP_OFF_CTRL, 8'h08);
        for (int ch = 0; ch < 2; ch++) begin
            flag = (ch == 1) ? 8'h80 : 8'h40;
            lo = (ch == 1) ? `TCP_OFF_CAP_B_LO : `TCP_OFF_CAP_A_LO;
            ev(ch[0], 16'h1234);
            chk(ch ? cap_b_val : cap_a_val, 16'h1234);
            ev(ch[0], 16'h5678);
            rdchk(`TCP_OFF_CTRL, 8'h08 | flag);
            chk(ch ? cap_b_val : cap_a_val, 16'h1234);
            ev(ch[0], 16'h9abc);
            rdchk(lo, 8'h34);
            rdchk(`TCP_OFF_CTRL, 8'h08 | flag);
            rdchk(lo + 8'h01, 8'h12);
            rdchk(`TCP_OFF_CTRL, 8'h08);
            ev(ch[0], 16'h5678);
            chk(ch ? cap_b_val : cap_a_val, 16'h5678);
            rdchk(lo + 8'h01, 8'h56);
            rdchk(lo, 8'h78);
        end
        // With the period register selected, capture A events are dropped.
        wr(`TCP_OFF_CTRL, 8'h00);
        ev(1'b0, 16'h9abc);
        tick(1);
        chk(cap_a_val, 16'h5678);
        rdchk(`TCP_OFF_CTRL, 8'h00);
        // Interrupt: raise, mask, clear, and a read-only status write.
        rdchk(`TCP_OFF_IRQ_STAT, 8'h0f);
        wr(`TCP_OFF_IRQ_EN, 8'h02);
        tick(2);
        chk(16'(irq_out), 16'h0001);
        wr(`TCP_OFF_IRQ_EN, 8'h00);
        tick(2);
        chk(16'(irq_out), 16'h0000);
        wr(`TCP_OFF_IRQ_EN, 8'h02);
        wr(`TCP_OFF_IRQ_CLR, 8'h02);
        tick(2);
        chk(16'(irq_out), 16'h0000);
        rdchk(`TCP_OFF_IRQ_STAT, 8'h0d);
        rdchk(`TCP_OFF_IRQ_EN, 8'h02);
        ev(1'b1, 16'h4321);
        tick(3);
        chk(16'(irq_out), 16'h0001);
        wr(`TCP_OFF_IRQ_STAT, 8'h00);
        rdchk(`TCP_OFF_IRQ_STAT, 8'h0f);
        rdchk(8'h40, 8'h00);
        // Overrun flags ignore writes; a reset in mid-run clears the register.
        ev(1'b1, 16'h1111);
        wr(`TCP_OFF_CTRL, 8'h3f);
        rdchk(`TCP_OFF_CTRL, 8'hbf);
        wr(`TCP_OFF_CTRL, 8'h00);
        rdchk(`TCP_OFF_CTRL, 8'h80);
        @(posedge clk_sys_in);
        rstn_in <= 1'b0;
        tick(2);
        chk(16'({ctl_outs, irq_out, pin_a, pin_b}), 16'h0000);
        chk(16'(rdata_out), 16'h0000);
        @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        rdchk(`TCP_OFF_CTRL, 8'h00);
        tally_and_finish;
    end
endmodule

`default_nettype wire
